// File: core/ecst_status.sv
// error correction status flags, pending flag and halt/interrupt
`timescale 1ns/10ps
`include "ecst_regs.svh"
module ecst_status (
    input  wire logic              core_clk,      // 250 MHz clock
    input  wire logic              nrst,          // sync reset, low
    input  wire logic              ce,            // clock enable
    input  wire ecst_pkg::ecst_bus_t bus,         // register access
    output logic [7:0]             rdata_r,       // read data
    input  wire ecst_pkg::ecst_evt_t evt,         // corrector events
    input  wire logic              corr_busy,     // corrector working
    input  wire logic              irq_en,        // ecc interrupt enable
    input  wire logic              read_op,       // sector read active
    input  wire logic              read_cont,     // continuous read set
    input  wire logic              vec_xfer,      // vector transfer active
    input  wire logic              vector_ready_handshake, // partner ready
    input  wire logic              vector_fault_signal,    // partner fault
    input  wire logic              wr_op,         // sector write active
    input  wire logic              wr_byte_vld,   // write byte strobe
    input  wire logic [7:0]        wr_byte,       // write data byte
    input  wire logic              cks_vld,       // partner checksum here
    input  wire logic [7:0]        cks_in,        // partner checksum
    input  wire logic              xfer_active,   // data transfer active
    input  wire logic              bufaddr_wr,    // buffer address write
    input  wire logic              op_done,       // operation completed
    input  wire logic              op_ack,        // completion flag cleared
    output logic [7:0]             flags_r,       // status register
    output logic                   pend_r,        // ecc error pending
    output logic                   halt_r,        // stop operation
    output logic                   irq_r          // interrupt request
);
    // ------------------------------------------------------------
    // event decode
    // ------------------------------------------------------------
    logic [7:0] set_v;
    logic [7:0] sum_w;
    logic [1:0] done_cnt_r;
    logic       vec_prev_r;
    logic       wr_isr_pend;
    logic       opovr_evt;
    logic       quiet_upper;
    logic [7:0] gate_mask;
    logic       pend_evt;

    ecst_cksum #(.W(8)) u_cksum (
        .core_clk (core_clk),
        .nrst     (nrst),
        .ce       (ce),
        .clr      (!wr_op),
        .byte_vld (wr_byte_vld && wr_op),
        .byte_in  (wr_byte),
        .sum_r    (sum_w)
    );

    assign wr_isr_pend = bus.wr && bus.addr == `ECST_ISR_OFS
                         && bus.wdata[`ECST_ISR_PEND_BIT];
    // third completion while the first is still unacknowledged
    assign opovr_evt = op_done && !op_ack && done_cnt_r == 2'h2;

    always_comb begin
        set_v = 8'h00;
        set_v[`ECST_BIT_UNC_ECC] = evt.unc_ecc;
        set_v[`ECST_BIT_UNC_CRC] = evt.crc_done && evt.crc_nonzero
                                   && !evt.unc_ecc
                                   && !flags_r[`ECST_BIT_UNC_ECC];
        set_v[`ECST_BIT_THRESH]  = evt.thresh;
        set_v[`ECST_BIT_OVERRUN] = evt.next_crc1 && corr_busy;
        set_v[`ECST_BIT_HWFAULT] = evt.hw_fault;
        // ready held high across a vector beat is a sync error
        set_v[`ECST_BIT_VECSYNC] = (vec_xfer && vec_prev_r
                                    && vector_ready_handshake)
                                   || vector_fault_signal;
        set_v[`ECST_BIT_CKSUM]   = wr_op && cks_vld
                                   && cks_in != sum_w;
        set_v[`ECST_BIT_OPOVR]   = (bufaddr_wr && xfer_active)
                                   || opovr_evt;
    end

    // upper flags still set but raise no pending, halt or interrupt during a continuous read
    assign quiet_upper = read_op && read_cont;
    assign gate_mask   = quiet_upper ? ~`ECST_UPPER_MASK : 8'hFF;
    assign pend_evt    = |(set_v & gate_mask);

    // ------------------------------------------------------------
    // history registers
    // ------------------------------------------------------------
    // vector ready sampled a cycle back for the sync check
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            vec_prev_r <= 1'b0;
        end else if (ce) begin
            vec_prev_r <= vec_xfer && vector_ready_handshake;
        end
    end

    // unacknowledged completions; saturates at two
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            done_cnt_r <= 2'h0;
        end else if (ce) begin
            if (op_ack) begin
                done_cnt_r <= op_done ? 2'h1 : 2'h0;
            end else if (op_done && done_cnt_r != 2'h2) begin
                done_cnt_r <= done_cnt_r + 2'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // status flags
    // ------------------------------------------------------------
    // set wins over clear so no event is lost at the clear edge
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            flags_r <= `ECST_FAULT_RST;
        end else if (ce) begin
            if (wr_isr_pend) begin
                flags_r <= set_v;
            end else if (evt.sector_start) begin
                flags_r <= (flags_r & ~`ECST_UPPER_MASK) | set_v;
            end else begin
                flags_r <= flags_r | set_v;
            end
        end
    end

    // pending flag, halt and interrupt
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            pend_r <= 1'b0;
            halt_r <= 1'b0;
            irq_r  <= 1'b0;
        end else if (ce) begin
            pend_r <= pend_evt || (pend_r && !wr_isr_pend);
            halt_r <= (pend_evt && irq_en)
                      || (halt_r && !wr_isr_pend);
            irq_r  <= (pend_evt && irq_en)
                      || (irq_r && !wr_isr_pend);
        end
    end

    // ------------------------------------------------------------
    // read port; writes to the status offset are ignored
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            rdata_r <= 8'h00;
        end else if (ce && bus.rd) begin
            unique case (bus.addr)
                `ECST_FAULT_FLAGS_OFS: rdata_r <= flags_r;
                `ECST_ISR_OFS:         rdata_r <= {7'h00, pend_r};
                default:               rdata_r <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_clear_write;
        ce && wr_isr_pend && set_v == 8'h00;
    endsequence

    property p_pend_on_set;
        @(posedge core_clk) disable iff (!nrst)
        (ce && pend_evt) |=> pend_r;
    endproperty
    a_pend_on_set: assert property (p_pend_on_set)
        else $error("pending not raised by error event");

    property p_irq_when_en;
        @(posedge core_clk) disable iff (!nrst)
        (ce && pend_evt && irq_en) |=> (irq_r && halt_r);
    endproperty
    a_irq_when_en: assert property (p_irq_when_en)
        else $error("interrupt or halt missing");

    property p_clear_all;
        @(posedge core_clk) disable iff (!nrst)
        s_clear_write |=> (flags_r == 8'h00 && !pend_r);
    endproperty
    a_clear_all: assert property (p_clear_all)
        else $error("flags not cleared by pending write");

    property p_quiet_upper;
        @(posedge core_clk) disable iff (!nrst)
        (ce && quiet_upper && !pend_r && (set_v & 8'h0F) == 8'h00
         && !wr_isr_pend) |=> !pend_r;
    endproperty
    a_quiet_upper: assert property (p_quiet_upper)
        else $error("upper flag raised pending in continuous read");

    property p_sector_clear;
        @(posedge core_clk) disable iff (!nrst)
        (ce && evt.sector_start && set_v == 8'h00)
            |=> (flags_r[7:4] == 4'h0);
    endproperty
    a_sector_clear: assert property (p_sector_clear)
        else $error("upper flags survive sector start");

    property p_unc_ecc;
        @(posedge core_clk) disable iff (!nrst)
        (ce && evt.unc_ecc) |=> flags_r[`ECST_BIT_UNC_ECC];
    endproperty
    a_unc_ecc: assert property (p_unc_ecc)
        else $error("ecc uncorrectable flag not set");

    property p_overrun;
        @(posedge core_clk) disable iff (!nrst)
        (ce && evt.next_crc1 && corr_busy) |=> flags_r[4];
    endproperty
    a_overrun: assert property (p_overrun)
        else $error("overrun flag not set");

    property p_vfault;
        @(posedge core_clk) disable iff (!nrst)
        (ce && vector_fault_signal) |=> flags_r[2];
    endproperty
    a_vfault: assert property (p_vfault)
        else $error("vector fault not flagged");

    property p_ro;
        @(posedge core_clk) disable iff (!nrst)
        (ce && bus.wr && bus.addr == `ECST_FAULT_FLAGS_OFS
         && !evt.sector_start && !wr_isr_pend)
            |=> (flags_r & $past(flags_r)) == $past(flags_r);
    endproperty
    a_ro: assert property (p_ro)
        else $error("write changed read-only status");

    property p_sticky;
        @(posedge core_clk) disable iff (!nrst)
        (ce && flags_r[0] && !wr_isr_pend) |=> flags_r[0];
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("flag dropped without clear");

    property p_unc_crc;
        @(posedge core_clk) disable iff (!nrst)
        (ce && evt.crc_done && evt.crc_nonzero && !evt.unc_ecc
         && !flags_r[`ECST_BIT_UNC_ECC]) |=> flags_r[`ECST_BIT_UNC_CRC];
    endproperty
    a_unc_crc: assert property (p_unc_crc)
        else $error("miscorrection flag not set");

    property p_thresh;
        @(posedge core_clk) disable iff (!nrst)
        (ce && evt.thresh) |=> flags_r[`ECST_BIT_THRESH];
    endproperty
    a_thresh: assert property (p_thresh)
        else $error("threshold flag not set");

    property p_hwfault;
        @(posedge core_clk) disable iff (!nrst)
        (ce && evt.hw_fault) |=> flags_r[`ECST_BIT_HWFAULT];
    endproperty
    a_hwfault: assert property (p_hwfault)
        else $error("hardware fault flag not set");

    sequence s_ready_held;
        ce && vec_xfer && vector_ready_handshake
        ##1 ce && vec_xfer && vector_ready_handshake;
    endsequence

    property p_vec_sync;
        @(posedge core_clk) disable iff (!nrst)
        s_ready_held |=> flags_r[`ECST_BIT_VECSYNC];
    endproperty
    a_vec_sync: assert property (p_vec_sync)
        else $error("ready held in vector transfer not flagged");

    property p_cksum;
        @(posedge core_clk) disable iff (!nrst)
        (ce && wr_op && cks_vld && cks_in != sum_w)
            |=> flags_r[`ECST_BIT_CKSUM];
    endproperty
    a_cksum: assert property (p_cksum)
        else $error("checksum mismatch not flagged");

    property p_bufaddr;
        @(posedge core_clk) disable iff (!nrst)
        (ce && bufaddr_wr && xfer_active) |=> flags_r[`ECST_BIT_OPOVR];
    endproperty
    a_bufaddr: assert property (p_bufaddr)
        else $error("buffer address write in transfer not flagged");

    property p_third_done;
        @(posedge core_clk) disable iff (!nrst)
        (ce && opovr_evt) |=> flags_r[`ECST_BIT_OPOVR];
    endproperty
    a_third_done: assert property (p_third_done)
        else $error("third completion not flagged");
endmodule : ecst_status

// File: core/ecst_regs.svh
// register offsets, field positions and reset values for error status
`ifndef ECST_REGS_SVH
`define ECST_REGS_SVH
`define ECST_FAULT_FLAGS_OFS  8'h30
`define ECST_ISR_OFS          8'h3A
`define ECST_FAULT_RST        8'h00
`define ECST_BIT_UNC_ECC      7
`define ECST_BIT_UNC_CRC      6
`define ECST_BIT_THRESH       5
`define ECST_BIT_OVERRUN      4
`define ECST_BIT_HWFAULT      3
`define ECST_BIT_VECSYNC      2
`define ECST_BIT_CKSUM        1
`define ECST_BIT_OPOVR        0
`define ECST_ISR_PEND_BIT     0
`define ECST_UPPER_MASK       8'hF0
`endif

// File: core/ecst_pkg.sv
// types shared by the error status block
package ecst_pkg;
    // one-cycle error events from the corrector
    typedef struct packed {
        logic unc_ecc;      // corrector gave up on the sector
        logic crc_done;     // correction finished, residue valid
        logic crc_nonzero;  // adjusted residue not zero
        logic thresh;       // a threshold exceeded
        logic next_crc1;    // first crc byte of next sector read
        logic hw_fault;     // internal parity error
        logic sector_start; // corrector begins a sector
    } ecst_evt_t;
    // microcontroller register port
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ecst_bus_t;
endpackage : ecst_pkg

// File: core/ecst_cksum.sv
// 8-bit running checksum over write-path bytes
`timescale 1ns/10ps
module ecst_cksum #(
    parameter int W = 8                 // checksum width
) (
    input  wire logic         core_clk,   // clock
    input  wire logic         nrst,       // sync reset, active low
    input  wire logic         ce,         // clock enable
    input  wire logic         clr,        // start of sector
    input  wire logic         byte_vld,   // byte strobe
    input  wire logic [W-1:0] byte_in,    // data byte
    output logic      [W-1:0] sum_r       // running checksum
);
    // xor accumulate; cheap and matches a byte-wide checker
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            sum_r <= '0;
        end else if (ce) begin
            if (clr) begin
                sum_r <= '0;
            end else if (byte_vld) begin
                sum_r <= sum_r ^ byte_in;
            end
        end
    end
endmodule : ecst_cksum

// File: sim/ecst_partner.sv
// behavioural model of the companion disk controller
`timescale 1ns/10ps
module ecst_partner (
    input  wire logic       core_clk,    // clock
    input  wire logic       nrst,        // sync reset, low
    input  wire logic       vec_xfer,    // vector transfer active
    input  wire logic       bad_vec,     // keep ready up in transfer
    input  wire logic       fault_req,   // raise vector fault
    input  wire logic       wr_op,       // sector write active
    input  wire logic       wr_byte_vld, // write byte strobe
    input  wire logic [7:0] wr_byte,     // write byte
    input  wire logic       send_cks,    // send checksum now
    input  wire logic       bad_cks,     // corrupt checksum
    output logic            rdy,         // vector ready handshake
    output logic            flt,         // vector fault signal
    output logic            cks_vld,     // checksum strobe
    output logic [7:0]      cks_in       // checksum
);
    logic [7:0] sum_r; // running xor of write bytes
    // ready stays low in a transfer unless told to misbehave
    always_ff @(posedge core_clk) begin
        rdy <= nrst & bad_vec & vec_xfer;
        flt <= nrst & fault_req;
    end
    // idle checksum lines carry junk so a stale value never matches
    always_ff @(posedge core_clk) begin
        if (!wr_op) sum_r <= 8'h00;
        else if (wr_byte_vld) sum_r <= sum_r ^ wr_byte;
        cks_vld <= send_cks;
        cks_in <= send_cks ? sum_r ^ {7'h00, bad_cks} : ~sum_r;
    end
endmodule : ecst_partner

// File: sim/ecst_status_tb.sv
// self-checking bench for the error status block
`timescale 1ns/10ps
`include "ecst_regs.svh"
module ecst_status_tb;
    logic core_clk = 1'b0, nrst = 1'b0, irq_en = 1'b0, corr_busy = 1'b0;
    logic read_op = 1'b0, read_cont = 1'b0, vec_xfer = 1'b0, wr_op = 1'b0;
    logic wr_byte_vld = 1'b0, xfer_active = 1'b0, bufaddr_wr = 1'b0;
    logic op_done = 1'b0, op_ack = 1'b0, bad_vec = 1'b0, fault_req = 1'b0;
    logic send_cks = 1'b0, bad_cks = 1'b0, rdy, flt, cks_vld;
    logic ce = 1'b1; // clock enable, dropped by the freeze check
    logic pend_r, halt_r, irq_r;
    logic [7:0] wr_byte = 8'h00, cks_in, rdata_r, flags_r;
    ecst_pkg::ecst_bus_t bus = '0;
    ecst_pkg::ecst_evt_t evt = '0;
    int mismatches = 0, checked = 0, cyc = 0;
    logic [6:0] ev [5] = '{7'h30, 7'h08, 7'h04, 7'h02, 7'h70};
    logic [7:0] ex [5] = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h80};
    ecst_status u_dut (.core_clk(core_clk), .nrst(nrst), .ce(ce),
        .bus(bus), .rdata_r(rdata_r), .evt(evt), .corr_busy(corr_busy),
        .irq_en(irq_en), .read_op(read_op), .read_cont(read_cont),
        .vec_xfer(vec_xfer), .vector_ready_handshake(rdy),
        .vector_fault_signal(flt), .wr_op(wr_op), .wr_byte_vld(wr_byte_vld),
        .wr_byte(wr_byte), .cks_vld(cks_vld), .cks_in(cks_in),
        .xfer_active(xfer_active), .bufaddr_wr(bufaddr_wr),
        .op_done(op_done), .op_ack(op_ack), .flags_r(flags_r),
        .pend_r(pend_r), .halt_r(halt_r), .irq_r(irq_r));
    ecst_partner u_far (.core_clk(core_clk), .nrst(nrst),
        .vec_xfer(vec_xfer), .bad_vec(bad_vec), .fault_req(fault_req),
        .wr_op(wr_op), .wr_byte_vld(wr_byte_vld), .wr_byte(wr_byte),
        .send_cks(send_cks), .bad_cks(bad_cks), .rdy(rdy), .flt(flt),
        .cks_vld(cks_vld), .cks_in(cks_in));
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    // cut a hang short well past the expected run of under two hundred cycles
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 4000) begin
            mismatches++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wt(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : wt
    // outputs are read 1 ns past the edge so the edge's updates have landed
    task automatic st(input logic [7:0] f, input logic [2:0] p);
        chk(flags_r, f);
        chk({5'h00, pend_r, irq_r, halt_r}, {5'h00, p});
    endtask : st
    task automatic acc(input logic w, input logic [7:0] a, d);
        @(posedge core_clk);
        bus <= {w, ~w, a, d};
        @(posedge core_clk);
        bus <= '0;
        wt(1);
    endtask : acc
    task automatic clr();
        acc(1'b1, `ECST_ISR_OFS, 8'h01);
        st(8'h00, 3'h0);
    endtask : clr
    task automatic pulse(input logic [6:0] e);
        @(posedge core_clk);
        evt <= ecst_pkg::ecst_evt_t'(e);
        @(posedge core_clk);
        evt <= '0;
        wt(2);
    endtask : pulse
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_unc();
        irq_en <= 1'b1;
        pulse(7'h40);
        st(8'h80, 3'h7);
        wt(6);
        st(8'h80, 3'h7);
        acc(1'b1, `ECST_FAULT_FLAGS_OFS, 8'h00);
        acc(1'b0, `ECST_FAULT_FLAGS_OFS, 8'h00);
        chk(rdata_r, 8'h80);
        acc(1'b0, 8'h55, 8'h00);
        chk(rdata_r, 8'h00);
        clr();
        irq_en <= 1'b0;
    endtask : t_unc
    task automatic t_tbl();
        corr_busy <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            pulse(ev[i]);
            st(ex[i], 3'h4);
            clr();
        end
        corr_busy <= 1'b0;
        pulse(7'h04);
        st(8'h00, 3'h0);
    endtask : t_tbl
    task automatic t_cont();
        irq_en <= 1'b1;
        read_op <= 1'b1;
        read_cont <= 1'b1;
        pulse(7'h08);
        st(8'h20, 3'h0);
        pulse(7'h01);
        st(8'h00, 3'h0);
        pulse(7'h02);
        st(8'h08, 3'h7);
        clr();
        read_op <= 1'b0;
        read_cont <= 1'b0;
        irq_en <= 1'b0;
    endtask : t_cont
    task automatic vecx(input logic b, input logic [7:0] f);
        @(posedge core_clk);
        vec_xfer <= 1'b1;
        bad_vec <= b;
        wt(4);
        vec_xfer <= 1'b0;
        bad_vec <= 1'b0;
        wt(2);
        st(f, {b, 2'h0});
    endtask : vecx
    task automatic cks(input logic b);
        @(posedge core_clk);
        wr_op <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            @(posedge core_clk);
            wr_byte_vld <= 1'b1;
            wr_byte <= 8'hA5 ^ 8'(i * 37);
        end
        @(posedge core_clk);
        wr_byte_vld <= 1'b0;
        send_cks <= 1'b1;
        bad_cks <= b;
        @(posedge core_clk);
        send_cks <= 1'b0;
        wt(2);
        wr_op <= 1'b0;
        st({6'h00, b, 1'b0}, {b, 2'h0});
    endtask : cks
    task automatic ops(input int n);
        repeat (n) begin
            @(posedge core_clk);
            op_done <= 1'b1;
            @(posedge core_clk);
            op_done <= 1'b0;
        end
        wt(2);
    endtask : ops
    task automatic t_misc();
        vecx(1'b0, 8'h00);
        vecx(1'b1, 8'h04);
        clr();
        fault_req <= 1'b1;
        wt(2);
        fault_req <= 1'b0;
        wt(2);
        st(8'h04, 3'h4);
        clr();
        cks(1'b0);
        cks(1'b1);
        clr();
        xfer_active <= 1'b1;
        bufaddr_wr <= 1'b1;
        wt(1);
        bufaddr_wr <= 1'b0;
        xfer_active <= 1'b0;
        wt(2);
        st(8'h01, 3'h4);
        clr();
        ops(2);
        st(8'h00, 3'h0);
        ops(1);
        st(8'h01, 3'h4);
        clr();
        op_ack <= 1'b1;
        wt(1);
        op_ack <= 1'b0;
        ops(2);
        st(8'h00, 3'h0);
        // a frozen clock enable must swallow the clear write
        pulse(7'h40);
        ce <= 1'b0;
        acc(1'b1, `ECST_ISR_OFS, 8'h01);
        st(8'h80, 3'h4);
        ce <= 1'b1;
        clr();
    endtask : t_misc
    initial begin
        repeat (8) @(posedge core_clk);
        nrst <= 1'b1;
        wt(1);
        st(`ECST_FAULT_RST, 3'h0);
        t_unc();
        t_tbl();
        t_cont();
        t_misc();
        end_sim();
    end
endmodule : ecst_status_tb
